// ==== hw/cilm_defs.svh ====
// Constants of the identifier level monitor and trigger.
// Behaviour
// - Pulse the trigger on the chosen 11-bit or 29-bit identifier or error frame.
// - Trigger source is one of standard match, extended match or error frame.
// - Run bit-rate detection, then identifier scan, then level measurement, in order.
// - The scan always lasts the full scan time and records every distinct 11-bit identifier (in CANopen, every node ID) that its mode accepts.
// - Scan time defaults to ten seconds.
// - Measurement ends at the latest when the maximum measuring time expires.
// - Measurement ends early once all entries hold all samples; averaging defaults to 3.
// - Every entry keeps its own sample counter.
// - Layer 2 list holds up to 2048 identifiers.
// - CANopen list holds up to 127 node IDs.
// - A frame qualifies for sampling only with a data length code of at least 1.
// - A frame qualifies only with two consecutive dominant bits, the second in the first data byte.
// - Entries heard in measurement but never qualifying are flagged as lacking usable bits, per level.
// - Entries short of samples at timeout are flagged non-periodic, with no result, for each level whose samples fall short.
// - CANopen records nodes only from heartbeat, guarding or first SDO response ids.
// - An entry is complete after twice the averaging factor samples.
// - Inverted bus polarity blocks scan, measurement and trigger.
`ifndef CILM_DEFS_SVH
`define CILM_DEFS_SVH
`define CILM_CLK_HZ 10000000
`define CILM_SCAN_TIME_S 10
`define CILM_MEAS_TIME_S 60
`define CILM_TRIG_PULSE_NS 1000
`define CILM_SCAN_CYCLES (`CILM_SCAN_TIME_S * `CILM_CLK_HZ)
`define CILM_MEAS_CYCLES (`CILM_MEAS_TIME_S * `CILM_CLK_HZ)
`define CILM_TRIG_CYCLES ((`CILM_TRIG_PULSE_NS * (`CILM_CLK_HZ / 1000000) + 999) / 1000)
`define CILM_AVG_DEFAULT 4'h3
`define CILM_L2_ENTRIES 2048
`define CILM_LAST_ENTRY 11'h7FF
`define CILM_FC_HEARTBEAT 4'hE
`define CILM_FC_SDO_RESP 4'hB
`define CILM_STD_ID_END 8'h0B
`define CILM_RTR_POS 8'h0C
`define CILM_IDE_POS 8'h0D
`define CILM_EXT_ID_END 8'h1F
`define CILM_EXT_RTR_POS 8'h20
`define CILM_STD_DATA_POS 8'h13
`define CILM_EXT_DATA_POS 8'h27
`define CILM_DLC_BITS 8'h04
`define CILM_BYTE_BITS 8'h08
`define CILM_MAX_DATA_BITS 8'h40
`define CILM_CRC_BITS 8'h0F
`define CILM_STUFF_RUN 3'h5
`define CILM_IDLE_BITS 4'hB
`endif

// ==== hw/cilm_entry_table.sv ====
// Per-entry record store: one write port and two asynchronous read ports.
`timescale 1ns/1ps
module cilm_entry_table
  import cilm_pkg::*;
#(
  parameter int ENTRIES = 2048
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [10:0] waddr,
  input cilm_entry_t wdata,
  input wire logic [10:0] raddr,
  output cilm_entry_t rdata,
  input wire logic [10:0] qaddr,
  output cilm_entry_t qdata
);
  // Not reset: the owner clears every word with a sweep before each scan.
  cilm_entry_t mem [0:ENTRIES-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
  assign qdata = mem[qaddr];
endmodule // cilm_entry_table

// ==== hw/cilm_monitor.sv ====
// Passive bus monitor: frame decoder, identifier scan, level sample scheduling and trigger.
`timescale 1ns/1ps
`include "cilm_defs.svh"
module cilm_monitor
  import cilm_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = `CILM_SCAN_CYCLES,
  parameter int unsigned MEAS_CYCLES = `CILM_MEAS_CYCLES,
  parameter logic [3:0] AVG = `CILM_AVG_DEFAULT,
  parameter logic [15:0] TRIG_CYCLES = 16'(`CILM_TRIG_CYCLES)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic can_rx_pin,
  input wire logic start,
  input cilm_mode_t mode_sel,
  input wire logic rate_ok,
  input wire logic polarity_inverted,
  input wire logic [15:0] bit_cycles,
  input wire logic trig_enable,
  input cilm_trig_src_t trig_src,
  input wire logic [28:0] trigger_match_value,
  input wire logic [10:0] entry_sel,
  output cilm_phase_t phase,
  output logic [11:0] entries_found,
  output logic [11:0] count_ok,
  output logic [11:0] count_non_periodic,
  output logic [11:0] count_no_bits,
  output logic meas_timed_out,
  output logic diff_sample_strobe,
  output logic abs_sample_strobe,
  output logic [10:0] sample_entry,
  output logic trig_pulse,
  output cilm_status_t entry_status
);
  cilm_mon_regs_t s_ff, nxt_s;
  cilm_entry_t rd_entry, q_entry, wr_entry;
  cilm_map_t mp;
  cilm_status_t cls;
  logic we, tick, b, rx_on, trig_hit, proc;
  logic [10:0] raddr;
  logic [7:0] dpos, stuff_end, data_bits;
  logic [3:0] two_avg;

  function automatic cilm_map_t map_entry(input cilm_frame_ev_t e, input cilm_mode_t m);
    cilm_map_t r;
    r.ok = 1'b0;
    r.idx = e.id[10:0];
    if (!e.ide) begin
      if (m == MODE_LAYER2) begin
        r.ok = 1'b1;
      end else if ((e.id[10:7] == `CILM_FC_HEARTBEAT || e.id[10:7] == `CILM_FC_SDO_RESP) &&
                   e.id[6:0] != 7'h00) begin
        r.ok = 1'b1;
        r.idx = {4'h0, e.id[6:0]};
      end
    end
    return r;
  endfunction

  function automatic cilm_status_t classify(input cilm_entry_t e, input logic [3:0] avg);
    cilm_status_t c;
    logic [3:0] two;
    two = {avg[2:0], 1'b0};
    c.seen = e.seen;
    c.complete = e.seen && e.cnt >= two;
    c.diff_ok = e.seen && e.cnt >= avg;
    c.abs_ok = c.complete;
    c.diff_no_bits = e.seen && e.heard && e.cnt == 4'h0;
    c.abs_no_bits = c.diff_no_bits;
    c.diff_non_periodic = e.seen && !c.diff_ok && !c.diff_no_bits;
    c.abs_non_periodic = e.seen && !c.abs_ok && !c.abs_no_bits;
    return c;
  endfunction

  cilm_entry_table #(
    .ENTRIES(`CILM_L2_ENTRIES)
  ) u_table (
    .ref_clk(ref_clk),
    .we(we),
    .waddr(s_ff.phase == PH_CLEAR ? s_ff.idx : mp.idx),
    .wdata(wr_entry),
    .raddr(raddr),
    .rdata(rd_entry),
    .qaddr(entry_sel),
    .qdata(q_entry)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.sync1 = can_rx_pin;
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.diff_stb = 1'b0;
    nxt_s.abs_stb = 1'b0;
    nxt_s.ev.id_done = 1'b0;
    nxt_s.ev.err = 1'b0;
    nxt_s.ev.qual = 1'b0;
    two_avg = {AVG[2:0], 1'b0};
    mp = map_entry(s_ff.ev, s_ff.mode);
    raddr = (s_ff.phase == PH_SUMMARY) ? s_ff.idx : mp.idx;
    cls = classify(rd_entry, AVG);
    we = 1'b0;
    wr_entry = rd_entry;
    // Scan, measurement and trigger all stop while the bit rate is unknown or inverted.
    rx_on = rate_ok && !polarity_inverted;

    // Frame decoder. Only the start of frame hard-syncs the bit clock, so long frames
    // at the edge of the bit-rate tolerance may be sampled late near their end.
    b = s_ff.sync2;
    tick = (s_ff.bcnt == 16'h0000);
    dpos = s_ff.ide ? `CILM_EXT_DATA_POS : `CILM_STD_DATA_POS;
    data_bits = s_ff.dlc[3] ? `CILM_MAX_DATA_BITS : {1'b0, s_ff.dlc, 3'b000};
    stuff_end = dpos + (s_ff.rtr ? 8'h00 : data_bits) + `CILM_CRC_BITS;
    nxt_s.bcnt = tick ? bit_cycles - 16'h0001 : s_ff.bcnt - 16'h0001;
    proc = 1'b0;
    case (s_ff.rx_st)
      RX_IDLE_WAIT: begin
        if (tick) begin
          if (!b) begin
            nxt_s.idle_cnt = 4'h0;
          end else if (s_ff.idle_cnt == `CILM_IDLE_BITS - 4'h1) begin
            nxt_s.rx_st = RX_READY;
          end else begin
            nxt_s.idle_cnt = s_ff.idle_cnt + 4'h1;
          end
        end
      end
      RX_READY: begin
        if (!b) begin
          nxt_s.rx_st = RX_FRAME;
          nxt_s.bcnt = {1'b0, bit_cycles[15:1]};
          nxt_s.n = 8'h00;
          nxt_s.run = 3'h0;
          nxt_s.last = 1'b1;
          nxt_s.prevb = 1'b1;
          nxt_s.id = 29'h0;
          nxt_s.ide = 1'b0;
          nxt_s.rtr = 1'b0;
          nxt_s.dlc = 4'h0;
          nxt_s.strobed = 1'b0;
        end
      end
      RX_FRAME: begin
        if (tick) begin
          if (s_ff.run == `CILM_STUFF_RUN) begin
            if (b == s_ff.last) begin
              // Six equal bits: an error flag is on the bus.
              nxt_s.ev.err = 1'b1;
              nxt_s.rx_st = RX_IDLE_WAIT;
              nxt_s.idle_cnt = 4'h0;
            end else begin
              nxt_s.run = 3'h1;
              nxt_s.last = b;
            end
          end else begin
            proc = 1'b1;
            nxt_s.run = (b == s_ff.last) ? s_ff.run + 3'h1 : 3'h1;
            nxt_s.last = b;
            nxt_s.prevb = b;
            nxt_s.n = s_ff.n + 8'h01;
          end
        end
      end
      default: begin
        nxt_s.rx_st = RX_IDLE_WAIT;
      end
    endcase

    if (proc) begin
      if (s_ff.n == 8'h00 && b) begin
        nxt_s.rx_st = RX_IDLE_WAIT;
        nxt_s.idle_cnt = 4'h0;
      end
      if (s_ff.n >= 8'h01 && s_ff.n <= `CILM_STD_ID_END) begin
        nxt_s.id = {s_ff.id[27:0], b};
      end
      if (s_ff.n == `CILM_RTR_POS) begin
        nxt_s.rtr = b;
      end
      if (s_ff.n == `CILM_IDE_POS) begin
        nxt_s.ide = b;
        if (!b) begin
          nxt_s.ev.id_done = 1'b1;
          nxt_s.ev.ide = 1'b0;
          nxt_s.ev.id = s_ff.id;
        end
      end
      if (s_ff.ide && s_ff.n > `CILM_IDE_POS && s_ff.n <= `CILM_EXT_ID_END) begin
        nxt_s.id = {s_ff.id[27:0], b};
      end
      if (s_ff.ide && s_ff.n == `CILM_EXT_ID_END) begin
        nxt_s.ev.id_done = 1'b1;
        nxt_s.ev.ide = 1'b1;
        nxt_s.ev.id = {s_ff.id[27:0], b};
      end
      if (s_ff.ide && s_ff.n == `CILM_EXT_RTR_POS) begin
        nxt_s.rtr = b;
      end
      if (s_ff.n >= dpos - `CILM_DLC_BITS && s_ff.n < dpos) begin
        nxt_s.dlc = {s_ff.dlc[2:0], b};
      end
      if (s_ff.n >= dpos && s_ff.n < dpos + `CILM_BYTE_BITS && !s_ff.rtr &&
          s_ff.dlc != 4'h0 &&
          !b && !s_ff.prevb && !s_ff.strobed) begin
        nxt_s.ev.qual = 1'b1;
        nxt_s.ev.ide = s_ff.ide;
        nxt_s.ev.id = s_ff.id;
        nxt_s.strobed = 1'b1;
      end
      if (s_ff.n >= dpos && s_ff.n + 8'h01 == stuff_end) begin
        nxt_s.rx_st = RX_IDLE_WAIT;
        nxt_s.idle_cnt = 4'h0;
      end
    end
    if (!rx_on) begin
      nxt_s.rx_st = RX_IDLE_WAIT;
      nxt_s.idle_cnt = 4'h0;
    end

    // Phase sequencing.
    case (s_ff.phase)
      PH_IDLE, PH_INVERTED, PH_DONE: begin
        if (start) begin
          nxt_s.phase = PH_RATE;
          nxt_s.mode = mode_sel;
          nxt_s.timed_out = 1'b0;
        end
      end
      PH_RATE: begin
        if (rate_ok) begin
          nxt_s.phase = polarity_inverted ? PH_INVERTED : PH_CLEAR;
          nxt_s.idx = 11'h000;
        end
      end
      PH_CLEAR: begin
        we = 1'b1;
        wr_entry = '0;
        nxt_s.idx = s_ff.idx + 11'h001;
        if (s_ff.idx == `CILM_LAST_ENTRY) begin
          nxt_s.phase = PH_SCAN;
          nxt_s.timer = 32'h0;
          nxt_s.seen_cnt = 12'h000;
        end
      end
      PH_SCAN: begin
        nxt_s.timer = s_ff.timer + 32'h1;
        if (s_ff.ev.id_done && mp.ok && !rd_entry.seen) begin
          we = 1'b1;
          wr_entry.seen = 1'b1;
          nxt_s.seen_cnt = s_ff.seen_cnt + 12'h001;
        end
        // No early exit: the scan runs to the last cycle of its window.
        if (s_ff.timer == 32'(SCAN_CYCLES - 1)) begin
          nxt_s.phase = PH_MEASURE;
          nxt_s.timer = 32'h0;
          nxt_s.done_cnt = 12'h000;
        end
      end
      PH_MEASURE: begin
        nxt_s.timer = s_ff.timer + 32'h1;
        if (s_ff.ev.id_done && mp.ok && rd_entry.seen) begin
          we = 1'b1;
          wr_entry.heard = 1'b1;
        end
        if (s_ff.ev.qual && mp.ok && rd_entry.seen && rd_entry.cnt < two_avg) begin
          we = 1'b1;
          wr_entry.heard = 1'b1;
          wr_entry.cnt = rd_entry.cnt + 4'h1;
          nxt_s.diff_stb = rd_entry.cnt < AVG;
          nxt_s.abs_stb = rd_entry.cnt >= AVG;
          nxt_s.sample_entry = mp.idx;
          if (rd_entry.cnt + 4'h1 == two_avg) begin
            nxt_s.done_cnt = s_ff.done_cnt + 12'h001;
          end
        end
        if (s_ff.done_cnt == s_ff.seen_cnt) begin
          nxt_s.phase = PH_SUMMARY;
          nxt_s.idx = 11'h000;
        end else if (s_ff.timer == 32'(MEAS_CYCLES - 1)) begin
          nxt_s.phase = PH_SUMMARY;
          nxt_s.timed_out = 1'b1;
          nxt_s.idx = 11'h000;
        end
        if (nxt_s.phase == PH_SUMMARY) begin
          nxt_s.ok_cnt = 12'h000;
          nxt_s.per_cnt = 12'h000;
          nxt_s.nobit_cnt = 12'h000;
        end
      end
      PH_SUMMARY: begin
        // Sweep the table once to count complete, non-periodic and bit-less entries.
        if (cls.complete) begin
          nxt_s.ok_cnt = s_ff.ok_cnt + 12'h001;
        end else if (cls.diff_no_bits) begin
          nxt_s.nobit_cnt = s_ff.nobit_cnt + 12'h001;
        end else if (cls.seen) begin
          nxt_s.per_cnt = s_ff.per_cnt + 12'h001;
        end
        nxt_s.idx = s_ff.idx + 11'h001;
        if (s_ff.idx == `CILM_LAST_ENTRY) begin
          nxt_s.phase = PH_DONE;
        end
      end
      default: begin
        nxt_s.phase = PH_IDLE;
      end
    endcase

    // Trigger on the registered decoder event.
    case (trig_src)
      TRG_STD_ID: trig_hit = s_ff.ev.id_done && !s_ff.ev.ide &&
                             s_ff.ev.id[10:0] == trigger_match_value[10:0];
      TRG_EXT_ID: trig_hit = s_ff.ev.id_done && s_ff.ev.ide &&
                             s_ff.ev.id == trigger_match_value;
      TRG_ERROR: trig_hit = s_ff.ev.err;
      default: trig_hit = 1'b0;
    endcase
    if (trig_hit && trig_enable && rx_on) begin
      nxt_s.trig_cnt = TRIG_CYCLES;
    end else if (s_ff.trig_cnt != 16'h0000) begin
      nxt_s.trig_cnt = s_ff.trig_cnt - 16'h0001;
    end
    nxt_s.trig_out = (nxt_s.trig_cnt != 16'h0000);

    // Entry results are only meaningful once the summary has finished.
    nxt_s.status = (s_ff.phase == PH_DONE) ? classify(q_entry, AVG) : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign phase = s_ff.phase;
  assign entries_found = s_ff.seen_cnt;
  assign count_ok = s_ff.ok_cnt;
  assign count_non_periodic = s_ff.per_cnt;
  assign count_no_bits = s_ff.nobit_cnt;
  assign meas_timed_out = s_ff.timed_out;
  assign diff_sample_strobe = s_ff.diff_stb;
  assign abs_sample_strobe = s_ff.abs_stb;
  assign sample_entry = s_ff.sample_entry;
  assign trig_pulse = s_ff.trig_out;
  assign entry_status = s_ff.status;
endmodule // cilm_monitor

// ==== hw/cilm_pkg.sv ====
// Types shared by the identifier level monitor and its entry table.
package cilm_pkg;
  typedef enum logic [2:0] {
    PH_IDLE, PH_RATE, PH_INVERTED, PH_CLEAR, PH_SCAN, PH_MEASURE, PH_SUMMARY, PH_DONE
  } cilm_phase_t;
  typedef enum logic [1:0] {TRG_STD_ID, TRG_EXT_ID, TRG_ERROR} cilm_trig_src_t;
  typedef enum logic {MODE_LAYER2, MODE_CANOPEN} cilm_mode_t;
  typedef enum logic [1:0] {RX_IDLE_WAIT, RX_READY, RX_FRAME} cilm_rx_state_t;
  typedef struct packed {
    logic id_done;
    logic err;
    logic qual;
    logic ide;
    logic [28:0] id;
  } cilm_frame_ev_t;
  typedef struct packed {
    logic seen;
    logic heard;
    logic [3:0] cnt;
  } cilm_entry_t;
  typedef struct packed {
    logic seen;
    logic complete;
    logic diff_ok;
    logic abs_ok;
    logic diff_non_periodic;
    logic abs_non_periodic;
    logic diff_no_bits;
    logic abs_no_bits;
  } cilm_status_t;
  typedef struct packed {
    logic ok;
    logic [10:0] idx;
  } cilm_map_t;
  typedef struct packed {
    logic sync1;
    logic sync2;
    cilm_phase_t phase;
    cilm_mode_t mode;
    logic [31:0] timer;
    logic [10:0] idx;
    logic [11:0] seen_cnt;
    logic [11:0] done_cnt;
    logic [11:0] ok_cnt;
    logic [11:0] per_cnt;
    logic [11:0] nobit_cnt;
    logic timed_out;
    logic diff_stb;
    logic abs_stb;
    logic [10:0] sample_entry;
    logic [15:0] trig_cnt;
    logic trig_out;
    cilm_status_t status;
    cilm_rx_state_t rx_st;
    logic [15:0] bcnt;
    logic [7:0] n;
    logic [2:0] run;
    logic last;
    logic prevb;
    logic [28:0] id;
    logic ide;
    logic rtr;
    logic [3:0] dlc;
    logic strobed;
    logic [3:0] idle_cnt;
    cilm_frame_ev_t ev;
  } cilm_mon_regs_t;
endpackage

// ==== testbench/cilm_can_node.sv ====
// Bus node model that sends standard, extended and error frames on the receive line.
`timescale 1ns/1ps
module cilm_can_node #(
  parameter int BIT_C = 10
) (
  input wire logic ref_clk,
  output logic can_rx_pin
);
  initial can_rx_pin = 1'b1;
  task automatic put(input logic b);
    can_rx_pin = b;
    repeat (BIT_C) @(negedge ref_clk);
  endtask
  task automatic send(input logic [28:0] id, input logic ext, input logic [3:0] dlc,
      input logic [7:0] d0, input logic err);
    logic q[$];
    logic [14:0] crc;
    logic last;
    int run;
    q = {1'b0};
    for (int i = 10; i >= 0; i--) q.push_back(ext ? id[i + 18] : id[i]);
    if (ext) begin
      q.push_back(1'b1);
      q.push_back(1'b1);
      for (int i = 17; i >= 0; i--) q.push_back(id[i]);
    end
    repeat (3) q.push_back(1'b0);
    for (int i = 3; i >= 0; i--) q.push_back(dlc[i]);
    if (dlc != 4'h0) for (int i = 7; i >= 0; i--) q.push_back(d0[i]);
    crc = 15'h0;
    foreach (q[k]) crc = {crc[13:0], 1'b0} ^ ((q[k] ^ crc[14]) ? 15'h4599 : 15'h0);
    for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
    // An error frame is a bare run of dominant bits that breaks the stuffing rule.
    if (err) q = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    last = 1'b1;
    run = 0;
    foreach (q[k]) begin
      put(q[k]);
      run = (q[k] == last) ? run + 1 : 1;
      last = q[k];
      if (run == 5 && !err) begin
        put(!last);
        last = !last;
        run = 1;
      end
    end
    repeat (13) put(1'b1);
  endtask
endmodule // cilm_can_node

// ==== testbench/cilm_monitor_chk.sv ====
// Port-level assertions for the identifier level monitor.
`timescale 1ns/1ps
module cilm_monitor_chk
  import cilm_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = 100,
  parameter int unsigned MEAS_CYCLES = 100,
  parameter logic [15:0] TRIG_CYCLES = 16'h000A
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rate_ok,
  input wire logic polarity_inverted,
  input wire logic trig_enable,
  input cilm_phase_t phase,
  input wire logic meas_timed_out,
  input wire logic diff_sample_strobe,
  input wire logic abs_sample_strobe,
  input wire logic trig_pulse,
  input cilm_status_t entry_status
);
  logic [31:0] scan_cnt_ff;
  logic [31:0] meas_cnt_ff;
  logic [15:0] hi_cnt_ff;
  logic stb;
  assign stb = diff_sample_strobe | abs_sample_strobe;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scan_cnt_ff <= 32'h0;
      meas_cnt_ff <= 32'h0;
      hi_cnt_ff <= 16'h0;
    end else begin
      scan_cnt_ff <= (phase == PH_SCAN) ? scan_cnt_ff + 32'h1 : 32'h0;
      meas_cnt_ff <= (phase == PH_MEASURE) ? meas_cnt_ff + 32'h1 : 32'h0;
      hi_cnt_ff <= trig_pulse ? hi_cnt_ff + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Counters restart at reset, so the edge after a reset is excluded.
  sequence scan_left_s;
    !$past(reset) && $past(phase) == PH_SCAN && phase != PH_SCAN;
  endsequence
  sequence pulse_end_s;
    !$past(reset) && $fell(trig_pulse);
  endsequence
  scan_full_a: assert property (scan_left_s |-> scan_cnt_ff == SCAN_CYCLES)
    else $error("Scan phase length is wrong.");
  phase_order_a: assert property (
    !$past(reset) && $changed(phase) && phase inside {PH_SCAN, PH_MEASURE}
    |-> $past(phase) == phase - 3'h1)
    else $error("Phase entered out of order.");
  meas_bound_a: assert property (phase == PH_MEASURE |-> meas_cnt_ff < MEAS_CYCLES)
    else $error("Measurement outlasted its limit.");
  timeout_src_a: assert property ($rose(meas_timed_out) |-> $past(phase) == PH_MEASURE)
    else $error("Timeout flag rose outside measurement.");
  strobe_single_a: assert property (stb |=> !stb && !diff_sample_strobe)
    else $error("Sample strobe longer than one cycle.");
  strobe_meas_a: assert property (stb |-> $past(phase) == PH_MEASURE ||
    $past(phase, 2) == PH_MEASURE)
    else $error("Sample strobe outside measurement.");
  // At the falling edge the counter already holds every cycle the pulse stood high.
  trig_width_a: assert property (pulse_end_s |-> hi_cnt_ff >= TRIG_CYCLES)
    else $error("Trigger pulse too short.");
  // The gate is applied at the edge that loads the pulse counter, one edge before the rise.
  trig_gate_a: assert property ($rose(trig_pulse) |-> $past(rate_ok) &&
    !$past(polarity_inverted) && $past(trig_enable))
    else $error("Trigger fired while gated off.");
  no_bits_a: assert property (entry_status.diff_no_bits |-> entry_status.abs_no_bits &&
    !entry_status.diff_ok && !entry_status.complete)
    else $error("No-bits entry also shows a result.");
  done_full_a: assert property (entry_status.complete |-> entry_status.diff_ok &&
    entry_status.abs_ok)
    else $error("Complete entry lacks a level result.");
  status_gate_a: assert property (phase != PH_DONE && $past(phase) != PH_DONE |->
    entry_status == 8'h00)
    else $error("Entry status shown outside done phase.");
endmodule // cilm_monitor_chk
bind cilm_monitor cilm_monitor_chk #(.SCAN_CYCLES(SCAN_CYCLES), .MEAS_CYCLES(MEAS_CYCLES),
  .TRIG_CYCLES(TRIG_CYCLES)) chk_u (.ref_clk, .reset, .rate_ok, .polarity_inverted,
  .trig_enable, .phase, .meas_timed_out, .diff_sample_strobe, .abs_sample_strobe,
  .trig_pulse, .entry_status);

// ==== testbench/tb_cilm_monitor.sv ====
// Self-checking bench for the identifier level monitor.
`timescale 1ns/1ps
module tb_cilm_monitor;
  import cilm_pkg::*;
  localparam int unsigned SCAN_C = 4000;
  localparam int unsigned MEAS_C = 8000;
  localparam logic [15:0] TRIG_C = 16'h0006;
  logic ref_clk, reset, can_rx_pin, start, rate_ok, polarity_inverted, trig_enable;
  cilm_mode_t mode_sel;
  cilm_trig_src_t trig_src;
  logic [15:0] bit_cycles;
  logic [28:0] trigger_match_value;
  logic [10:0] entry_sel, sample_entry;
  cilm_phase_t phase;
  logic [11:0] entries_found, count_ok, count_non_periodic, count_no_bits;
  logic meas_timed_out, diff_sample_strobe, abs_sample_strobe, trig_pulse;
  cilm_status_t entry_status;
  int fails, samples_checked, n_diff, n_abs, n_rise, t_run, t_width;
  time t0;
  cilm_monitor #(.SCAN_CYCLES(SCAN_C), .MEAS_CYCLES(MEAS_C), .AVG(4'h1),
    .TRIG_CYCLES(TRIG_C)) dut_u (.*);
  cilm_can_node #(.BIT_C(10)) node_u (.ref_clk(ref_clk), .can_rx_pin(can_rx_pin));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (diff_sample_strobe === 1'b1) n_diff++;
    if (abs_sample_strobe === 1'b1) n_abs++;
    if (trig_pulse === 1'b1) begin
      if (t_run == 0) n_rise++;
      t_run++;
    end else if (t_run != 0) begin
      t_width = t_run;
      t_run = 0;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wait_ph(input cilm_phase_t p);
    int k;
    k = 0;
    while (phase !== p && k < 20000) begin
      @(negedge ref_clk);
      k++;
    end
    chk(phase, p);
  endtask
  task automatic go(input cilm_mode_t m);
    mode_sel = m;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    n_diff = 0;
    n_abs = 0;
    n_rise = 0;
  endtask
  task automatic stat(input logic [10:0] sel, input logic [7:0] exp);
    entry_sel = sel;
    repeat (2) @(negedge ref_clk);
    chk(entry_status, exp);
  endtask
  task automatic t_inverted;
    go(MODE_LAYER2);
    repeat (20) @(negedge ref_clk);
    chk(phase, PH_RATE);
    rate_ok = 1'b1;
    polarity_inverted = 1'b1;
    wait_ph(PH_INVERTED);
    node_u.send(29'h123, 1'b0, 4'h1, 8'h00, 1'b0);
    chk(n_rise, 0);
    chk(phase, PH_INVERTED);
    polarity_inverted = 1'b0;
    // The decoder wants eleven recessive bit times before it accepts a start of frame.
    repeat (150) @(negedge ref_clk);
  endtask
  task automatic t_trigger;
    node_u.send(29'h123, 1'b0, 4'h1, 8'h00, 1'b0);
    chk(n_rise, 1);
    chk(t_width, TRIG_C);
    node_u.send(29'h124, 1'b0, 4'h1, 8'h00, 1'b0);
    chk(n_rise, 1);
    trig_src = TRG_EXT_ID;
    trigger_match_value = 29'h1ABCDE12;
    node_u.send(29'h1ABCDE12, 1'b1, 4'h1, 8'h00, 1'b0);
    chk(n_rise, 2);
    trig_src = TRG_ERROR;
    node_u.send(29'h0, 1'b0, 4'h0, 8'h00, 1'b1);
    chk(n_rise, 3);
    trig_enable = 1'b0;
    node_u.send(29'h0, 1'b0, 4'h0, 8'h00, 1'b1);
    chk(n_rise, 3);
  endtask
  task automatic t_timeout;
    go(MODE_LAYER2);
    wait_ph(PH_SCAN);
    t0 = $time;
    node_u.send(29'h0A1, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h0B2, 1'b0, 4'h0, 8'h00, 1'b0);
    node_u.send(29'h0C3, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h0D4, 1'b0, 4'h1, 8'h55, 1'b0);
    wait_ph(PH_MEASURE);
    chk(32'(($time - t0) / 100), SCAN_C);
    chk(entries_found, 12'h004);
    // The third frame of the first entry must not add a sample.
    repeat (3) node_u.send(29'h0A1, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h0C3, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h0B2, 1'b0, 4'h0, 8'h00, 1'b0);
    node_u.send(29'h0D4, 1'b0, 4'h1, 8'h55, 1'b0);
    chk(n_diff, 2);
    chk(n_abs, 1);
    chk(sample_entry, 11'h0C3);
    wait_ph(PH_DONE);
    chk(meas_timed_out, 1'b1);
    chk(count_ok, 12'h001);
    chk(count_non_periodic, 12'h001);
    chk(count_no_bits, 12'h002);
    stat(11'h0A1, 8'hF0);
    stat(11'h0B2, 8'h83);
    stat(11'h0D4, 8'h83);
    stat(11'h0C3, 8'hA4);
  endtask
  task automatic t_early;
    go(MODE_LAYER2);
    wait_ph(PH_SCAN);
    node_u.send(29'h0A1, 1'b0, 4'h1, 8'h00, 1'b0);
    wait_ph(PH_MEASURE);
    chk(entries_found, 12'h001);
    repeat (2) node_u.send(29'h0A1, 1'b0, 4'h1, 8'h00, 1'b0);
    chk(phase, PH_SUMMARY);
    wait_ph(PH_DONE);
    chk(meas_timed_out, 1'b0);
    chk(count_ok, 12'h001);
  endtask
  task automatic t_canopen;
    go(MODE_CANOPEN);
    wait_ph(PH_SCAN);
    node_u.send(29'h705, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h5A2, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h183, 1'b0, 4'h1, 8'h00, 1'b0);
    node_u.send(29'h700, 1'b0, 4'h1, 8'h00, 1'b0);
    wait_ph(PH_MEASURE);
    chk(entries_found, 12'h002);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {fails, samples_checked, n_diff, n_abs, n_rise, t_run, t_width} = '0;
    reset = 1'b1;
    start = 1'b0;
    mode_sel = MODE_LAYER2;
    rate_ok = 1'b0;
    polarity_inverted = 1'b0;
    bit_cycles = 16'h000A;
    trig_enable = 1'b1;
    trig_src = TRG_STD_ID;
    trigger_match_value = 29'h123;
    entry_sel = 11'h000;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chk(phase, PH_IDLE);
    chk(trig_pulse, 1'b0);
    t_inverted();
    t_trigger();
    t_timeout();
    t_early();
    t_canopen();
    complete_run();
  end
  initial begin
    #8000000;
    fails++;
    complete_run();
  end
endmodule // tb_cilm_monitor
